//--- shared/tws_pkg.sv
`default_nettype none
package tws_pkg;
    // -----------------------------------------------------------------
    // Array geometry
    // -----------------------------------------------------------------
    localparam int unsigned PAGE_COUNT = 512;
    localparam int unsigned PAGE_BYTES = 256;
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned MEM_BYTES = PAGE_COUNT * PAGE_BYTES;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PAGE_IDX_W = 8;
    localparam int unsigned ROW_W = ADDR_W - PAGE_IDX_W;

    // -----------------------------------------------------------------
    // Serial word format
    // -----------------------------------------------------------------
    localparam int unsigned BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] WORD_BITS = 4'h8;
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam int unsigned DEV_TYPE_LSB = 4;
    localparam int unsigned DEV_CS_UPPER_BIT = 3;
    localparam int unsigned DEV_CS_LOWER_BIT = 2;
    localparam int unsigned DEV_PAGE_BIT = 1;
    localparam int unsigned DEV_RW_BIT = 0;
    localparam int unsigned ADDR_PAGE_BIT = 16;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned T_PROG_MS = 5;
    // Longest time: integer division rounds down
    localparam int unsigned PROG_CYCLES = T_PROG_MS * (CLK_HZ / 1000);
    localparam int unsigned PROG_W = 18;
    localparam int unsigned FILT_CYCLES = 2;
    localparam int unsigned FILT_W = 2;

    // -----------------------------------------------------------------
    // Input pin slots of the filter bank
    // -----------------------------------------------------------------
    localparam int unsigned PIN_SCL = 0;
    localparam int unsigned PIN_SDA = 1;
    localparam int unsigned PIN_CS_UPPER = 2;
    localparam int unsigned PIN_CS_LOWER = 3;
    localparam int unsigned PIN_WP = 4;
    localparam int unsigned PIN_COUNT = 5;
    // Bus lines idle high, straps idle low
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 5'h03;

    // -----------------------------------------------------------------
    // Transaction states
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEVADR = 4'h1,
        ST_ADRHI = 4'h3,
        ST_ADRLO = 4'h2,
        ST_WDATA = 4'h6,
        ST_PROG = 4'h7,
        ST_RDATA = 4'h5,
        ST_RACK = 4'h4,
        ST_RWAIT = 4'hc
    } tws_state_t;
endpackage : tws_pkg
`default_nettype wire

//--- src/tws_pin_filter.sv
`timescale 1ns/1ns
`default_nettype none
module tws_pin_filter #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_pin,
    output logic o_level
);
    import tws_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [FILT_W-1:0] cnt;
        logic level;
    } tws_filt_t;

    tws_filt_t filt_ff;
    tws_filt_t nxt_filt;

    // -----------------------------------------------------------------
    // Two-stage synchroniser, then a stability filter on the second stage
    // -----------------------------------------------------------------
    always_comb begin
        nxt_filt = filt_ff;
        nxt_filt.s1 = i_pin;
        nxt_filt.s2 = filt_ff.s1;
        if (filt_ff.s2 == filt_ff.level) begin
            nxt_filt.cnt = '0;
        end else if (filt_ff.cnt == FILT_W'(FILT_CYCLES - 1)) begin
            nxt_filt.cnt = '0;
            nxt_filt.level = filt_ff.s2;
        end else begin
            nxt_filt.cnt = filt_ff.cnt + FILT_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            filt_ff <= '{s1: RST_VAL, s2: RST_VAL, cnt: '0, level: RST_VAL};
        end else begin
            filt_ff <= nxt_filt;
        end
    end

    assign o_level = filt_ff.level;
endmodule : tws_pin_filter
`default_nettype wire

//--- src/tws_mem_array.sv
`timescale 1ns/1ns
`default_nettype none
module tws_mem_array (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [tws_pkg::ADDR_W-1:0] i_waddr,
    input wire logic [tws_pkg::DATA_W-1:0] i_wdata,
    input wire logic [tws_pkg::ADDR_W-1:0] i_raddr,
    output logic [tws_pkg::DATA_W-1:0] o_rdata
);
    import tws_pkg::*;

    // Nonvolatile content has no reset; it keeps its value across I_RESET
    logic [DATA_W-1:0] mem [MEM_BYTES];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = mem[i_raddr];
endmodule : tws_mem_array
`default_nettype wire

//--- src/tws_top.sv
// Notes on behaviour
// - Input bits are taken at clock rise; output bits change at clock fall.
// - Unconnected chip-select inputs must be pulled low on the board; there is no internal pull-down.
// - Write-protect high blocks all programming; reads are unaffected.
// - Array is 512 pages of 256 bytes, 17-bit byte address.
// - Data falling while clock high is a start; commands begin with one.
// - Data rising while clock high is a stop; commands end with one.
// - Stop after read gives standby now; after write, once programming ends.
// - Words are eight bits; device pulls data low on ninth clock.
// - Standby after power-up, after read stop, after programming completes.
// - Device address word follows start; top nibble must be 1010.
// - Bits five and six must match chip selects, else no acknowledge.
// - Seventh address bit selects page, top bit of byte address.
// - Eighth bit: one means read, zero means write.
// - Byte write sends two address bytes then data, each acknowledged.
// - Stop ending a write starts timed programming; inputs ignored meanwhile.
// - Programming, erase included, completes within 5 ms.
// - Data line is open drain: pull low or release.
// - Page write bumps only low eight address bits, wrapping in page.
// - Address commands get no acknowledge while programming runs.
// - Address counter holds last address plus one; reads wrap at top, writes wrap within the page.
// - Master acknowledges read bytes to continue, ends with no-ack and stop.
`timescale 1ns/1ns
`default_nettype none
module tws_top #(
    parameter int unsigned PROG_CYCLES = tws_pkg::PROG_CYCLES
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic I_CHIP_SELECT_UPPER,
    input wire logic I_CHIP_SELECT_LOWER,
    input wire logic I_WP,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    output logic O_BUSY,
    output logic O_STANDBY
);
    import tws_pkg::*;

    localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(PROG_CYCLES - 1);
    localparam logic [PROG_W-1:0] PROG_PAGE_END = PROG_W'(PAGE_BYTES);

    typedef struct packed {
        tws_state_t state;
        logic scl_q;
        logic sda_q;
        logic [BIT_CNT_W-1:0] cnt;
        logic [DATA_W-1:0] shreg;
        logic [DATA_W-1:0] tx;
        logic in_ack;
        logic sda_oe;
        logic sda_out;
        logic wrote;
        logic [ADDR_W-1:0] pend;
        logic [ADDR_W-1:0] addr_cnt;
        logic [PAGE_BYTES-1:0] valid;
        logic [PAGE_BYTES-1:0][DATA_W-1:0] pbuf;
        logic [PROG_W-1:0] prog_cnt;
        logic busy;
        logic standby;
    } tws_core_t;

    tws_core_t st_ff;
    tws_core_t nxt_st;

    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_lvl;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic dev_match;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] rd_data;

    // Type code and both chip-select bits of a device address word
    function automatic logic addr_match(input logic [DATA_W-1:0] word, input logic cs_up, input logic cs_lo);
        return (word[DATA_W-1:DEV_TYPE_LSB] == DEV_TYPE_CODE) && (word[DEV_CS_UPPER_BIT] == cs_up)
            && (word[DEV_CS_LOWER_BIT] == cs_lo);
    endfunction : addr_match

    // -----------------------------------------------------------------
    // Input conditioning
    // -----------------------------------------------------------------
    // Chip selects and write protect must be pulled down on the board when unconnected
    assign pin_raw = {I_WP, I_CHIP_SELECT_LOWER, I_CHIP_SELECT_UPPER, I_SDA, I_SCL};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            tws_pin_filter #(
                .RST_VAL(PIN_IDLE[gi])
            ) u_filt (
                .i_clk(I_SYS_CLK),
                .i_reset(I_RESET),
                .i_pin(pin_raw[gi]),
                .o_level(pin_lvl[gi])
            );
        end
    endgenerate

    assign scl = pin_lvl[PIN_SCL];
    assign sda = pin_lvl[PIN_SDA];
    // Both lines share the same filter latency, so their relative order survives
    assign scl_rise = scl & ~st_ff.scl_q;
    assign scl_fall = ~scl & st_ff.scl_q;
    assign start_cond = scl & st_ff.scl_q & st_ff.sda_q & ~sda;
    assign stop_cond = scl & st_ff.scl_q & ~st_ff.sda_q & sda;
    assign dev_match = addr_match(st_ff.shreg, pin_lvl[PIN_CS_UPPER], pin_lvl[PIN_CS_LOWER]);

    // -----------------------------------------------------------------
    // Array and page commit
    // -----------------------------------------------------------------
    // The page buffer is copied one byte per cycle at the start of programming
    assign mem_we = (st_ff.state == ST_PROG) && (st_ff.prog_cnt < PROG_PAGE_END)
        && st_ff.valid[st_ff.prog_cnt[PAGE_IDX_W-1:0]];
    assign mem_waddr = {st_ff.pend[ADDR_W-1:PAGE_IDX_W], st_ff.prog_cnt[PAGE_IDX_W-1:0]};
    assign mem_wdata = st_ff.pbuf[st_ff.prog_cnt[PAGE_IDX_W-1:0]];

    tws_mem_array u_mem (
        .i_clk(I_SYS_CLK),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(st_ff.addr_cnt),
        .o_rdata(rd_data)
    );

    // -----------------------------------------------------------------
    // Transaction engine
    // -----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_q = scl;
        nxt_st.sda_q = sda;
        nxt_st.sda_out = 1'b0;
        if (st_ff.state == ST_PROG) begin
            // Bus is ignored here, so address commands get no acknowledge
            nxt_st.prog_cnt = st_ff.prog_cnt + PROG_W'(1);
            if (st_ff.prog_cnt == PROG_LAST) begin
                nxt_st.state = ST_IDLE;
                nxt_st.prog_cnt = '0;
            end
        end else if (start_cond) begin
            nxt_st.state = ST_DEVADR;
            nxt_st.cnt = '0;
            nxt_st.in_ack = 1'b0;
            nxt_st.sda_oe = 1'b0;
        end else if (stop_cond) begin
            nxt_st.in_ack = 1'b0;
            nxt_st.sda_oe = 1'b0;
            nxt_st.cnt = '0;
            if ((st_ff.state == ST_WDATA) && st_ff.wrote && !pin_lvl[PIN_WP]) begin
                nxt_st.state = ST_PROG;
                nxt_st.prog_cnt = '0;
            end else begin
                nxt_st.state = ST_IDLE;
            end
        end else if (st_ff.in_ack) begin
            if (scl_fall) begin
                nxt_st.in_ack = 1'b0;
                nxt_st.sda_oe = 1'b0;
                nxt_st.cnt = '0;
                if (st_ff.state == ST_RDATA) begin
                    nxt_st.sda_oe = ~st_ff.tx[DATA_W-1];
                    nxt_st.tx = {st_ff.tx[DATA_W-2:0], 1'b0};
                end
            end
        end else begin
            case (st_ff.state)
                ST_DEVADR, ST_ADRHI, ST_ADRLO, ST_WDATA: begin
                    if (scl_rise && (st_ff.cnt != WORD_BITS)) begin
                        nxt_st.shreg = {st_ff.shreg[DATA_W-2:0], sda};
                        nxt_st.cnt = st_ff.cnt + BIT_CNT_W'(1);
                    end else if (scl_fall && (st_ff.cnt == WORD_BITS)) begin
                        // Word complete: acknowledge pulled low across the ninth clock
                        nxt_st.in_ack = 1'b1;
                        nxt_st.sda_oe = 1'b1;
                        if (st_ff.state == ST_DEVADR) begin
                            if (!dev_match) begin
                                nxt_st.state = ST_IDLE;
                                nxt_st.in_ack = 1'b0;
                                nxt_st.sda_oe = 1'b0;
                            end else if (st_ff.shreg[DEV_RW_BIT]) begin
                                nxt_st.state = ST_RDATA;
                                nxt_st.tx = rd_data;
                                nxt_st.addr_cnt = st_ff.addr_cnt + ADDR_W'(1);
                            end else begin
                                nxt_st.state = ST_ADRHI;
                                nxt_st.pend[ADDR_PAGE_BIT] = st_ff.shreg[DEV_PAGE_BIT];
                            end
                        end else if (st_ff.state == ST_ADRHI) begin
                            nxt_st.state = ST_ADRLO;
                            nxt_st.pend[ADDR_PAGE_BIT-1:PAGE_IDX_W] = st_ff.shreg;
                        end else if (st_ff.state == ST_ADRLO) begin
                            // A dummy write leaves the counter at the loaded address
                            nxt_st.state = ST_WDATA;
                            nxt_st.pend[PAGE_IDX_W-1:0] = st_ff.shreg;
                            nxt_st.addr_cnt = {st_ff.pend[ADDR_W-1:PAGE_IDX_W], st_ff.shreg};
                            nxt_st.valid = '0;
                            nxt_st.wrote = 1'b0;
                        end else begin
                            // Later bytes of the same slot overwrite earlier ones
                            nxt_st.pbuf[st_ff.pend[PAGE_IDX_W-1:0]] = st_ff.shreg;
                            nxt_st.valid[st_ff.pend[PAGE_IDX_W-1:0]] = 1'b1;
                            nxt_st.pend[PAGE_IDX_W-1:0] = st_ff.pend[PAGE_IDX_W-1:0] + 8'h01;
                            nxt_st.addr_cnt = {st_ff.pend[ADDR_W-1:PAGE_IDX_W],
                                st_ff.pend[PAGE_IDX_W-1:0] + 8'h01};
                            nxt_st.wrote = 1'b1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise && (st_ff.cnt != WORD_BITS)) begin
                        nxt_st.cnt = st_ff.cnt + BIT_CNT_W'(1);
                    end else if (scl_fall && (st_ff.cnt == WORD_BITS)) begin
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.state = ST_RACK;
                    end else if (scl_fall) begin
                        nxt_st.sda_oe = ~st_ff.tx[DATA_W-1];
                        nxt_st.tx = {st_ff.tx[DATA_W-2:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    if (scl_rise && !sda) begin
                        nxt_st.state = ST_RDATA;
                        nxt_st.tx = rd_data;
                        nxt_st.addr_cnt = st_ff.addr_cnt + ADDR_W'(1);
                        nxt_st.cnt = '0;
                    end else if (scl_rise) begin
                        nxt_st.state = ST_RWAIT;
                    end
                end
                default: begin
                    nxt_st.sda_oe = 1'b0;
                end
            endcase
        end
        nxt_st.busy = (nxt_st.state == ST_PROG);
        nxt_st.standby = (nxt_st.state == ST_IDLE);
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            st_ff <= '{state: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, standby: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Only a low is ever driven; high comes from the external pull-up
    assign O_SDA_OUT = st_ff.sda_out;
    assign O_SDA_OE = st_ff.sda_oe;
    assign O_BUSY = st_ff.busy;
    assign O_STANDBY = st_ff.standby;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    AST_CAPTURE_ON_RISE: assert property (
        scl_rise && !st_ff.in_ack && (st_ff.cnt != WORD_BITS) && !start_cond && !stop_cond
        && ((st_ff.state == ST_DEVADR) || (st_ff.state == ST_WDATA))
        |=> (st_ff.shreg[0] == $past(sda)) && (st_ff.cnt == $past(st_ff.cnt) + BIT_CNT_W'(1)))
        else $error("Data bit not captured on clock rise");
    AST_DRIVE_ON_FALL: assert property (
        $rose(O_SDA_OE) |-> $past(scl_fall))
        else $error("Data line pulled low outside a clock fall");
    AST_OPEN_DRAIN: assert property (
        !O_SDA_OUT)
        else $error("Data line driven high");
    AST_ACK_ON_MATCH: assert property (
        (st_ff.state == ST_DEVADR) && !st_ff.in_ack && scl_fall && (st_ff.cnt == WORD_BITS)
        && dev_match && !start_cond && !stop_cond
        |=> O_SDA_OE && st_ff.in_ack ##1 (O_SDA_OE [*2]))
        else $error("Matching address not acknowledged");
    AST_NO_ACK_MISMATCH: assert property (
        (st_ff.state == ST_DEVADR) && !st_ff.in_ack && scl_fall && (st_ff.cnt == WORD_BITS)
        && !dev_match && !start_cond && !stop_cond
        |=> !O_SDA_OE && O_STANDBY)
        else $error("Mismatched address acknowledged");
    AST_SILENT_BUSY: assert property (
        O_BUSY |-> !O_SDA_OE)
        else $error("Line driven during programming");
    AST_START_RESTART: assert property (
        start_cond && (st_ff.state != ST_PROG) |=> (st_ff.state == ST_DEVADR) && (st_ff.cnt == '0) && !O_SDA_OE)
        else $error("Start did not restart decoding");
    AST_READ_STOP_IDLE: assert property (
        stop_cond && ((st_ff.state == ST_RDATA) || (st_ff.state == ST_RACK) || (st_ff.state == ST_RWAIT))
        |=> ##1 O_STANDBY && !O_BUSY)
        else $error("Read stop did not return to standby");
    AST_WP_BLOCKS: assert property (
        stop_cond && (st_ff.state == ST_WDATA) && pin_lvl[PIN_WP] |=> ##1 !O_BUSY && O_STANDBY)
        else $error("Programming started under write protect");
    AST_WRITE_PROGRAMS: assert property (
        stop_cond && (st_ff.state == ST_WDATA) && st_ff.wrote && !pin_lvl[PIN_WP]
        |=> ##1 (O_BUSY && !O_STANDBY) [*4])
        else $error("Write stop did not start programming");
    AST_PROG_END: assert property (
        (st_ff.state == ST_PROG) && (st_ff.prog_cnt == PROG_LAST) |=> ##1 O_STANDBY && !O_BUSY)
        else $error("Programming did not end on time");
    AST_PAGE_ROW_HELD: assert property (
        (st_ff.state == ST_WDATA) && $stable(st_ff.state)
        |-> $stable(st_ff.pend[ADDR_W-1:PAGE_IDX_W]))
        else $error("Page row changed during page write");
endmodule : tws_top
`default_nettype wire

//--- dv/tws_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tws_host_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // -------------------------------------------------------------
    // Bus master: clock stands high between frames
    // -------------------------------------------------------------
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : tick
    task automatic start();
        tick(4);
        o_sda_low = 1'b0;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b1;
        tick(4);
        o_scl = 1'b0;
    endtask : start
    task automatic stop();
        tick(2);
        o_sda_low = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_low = 1'b0;
        tick(4);
    endtask : stop
    // 160 ns per bit: low 6 clocks, high 2; the long low phase covers the device's turnaround
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        o_sda_low = ~b;
        tick(5);
        o_scl = 1'b1;
        tick(1);
        r = i_sda;
        tick(1);
        o_scl = 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], b);
            r[i] = b;
        end
        bit_io(~mack, b);
        ack = ~b;
    endtask : xfer
endmodule : tws_host_model
`default_nettype wire

//--- dv/tb_tws_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_tws_top;
    logic clk, rst, wp, csu, csl, host_scl, host_low, sda_w;
    logic sda_out, sda_oe, busy, stby, a;
    logic [7:0] r;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    // Row layout: upper strap, lower strap, device word, ack expected
    localparam logic [10:0] ROWS [9] = '{11'h141, 11'h160, 11'h150, 11'h148, 11'h551, 11'h349, 11'h759, 11'h740, 11'h145};

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    assign sda_w = (host_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    tws_top #(.PROG_CYCLES(300)) DUT (.I_SYS_CLK(clk), .I_RESET(rst), .I_SCL(host_scl), .I_SDA(sda_w),
        .I_CHIP_SELECT_UPPER(csu), .I_CHIP_SELECT_LOWER(csl), .I_WP(wp), .O_SDA_OUT(sda_out),
        .O_SDA_OE(sda_oe), .O_BUSY(busy), .O_STANDBY(stby));
    tws_host_model HOST (.i_clk(clk), .i_sda(sda_w), .o_scl(host_scl), .o_sda_low(host_low));

    // -------------------------------------------------------------
    // Comparison and transfer tasks
    // -------------------------------------------------------------
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic send(input logic [7:0] w);
        HOST.xfer(w, 1'b0, r, a);
        check("ack", 8'(a), 8'h01);
    endtask : send
    task automatic wr(input logic [7:0] dev, hi, lo, d0, d1, input logic two, prog);
        int n;
        n = 0;
        HOST.start();
        send(dev);
        send(hi);
        send(lo);
        send(d0);
        if (two)
            send(d1);
        HOST.stop();
        HOST.tick(4);
        check("busy", 8'(busy), 8'(prog));
        if (prog) begin
            HOST.start();
            HOST.xfer(8'ha0, 1'b0, r, a);
            check("poll ack", 8'(a), 8'h00);
            HOST.stop();
            while (busy !== 1'b0 && n < 400) begin
                HOST.tick(1);
                n++;
            end
            check("prog time", 8'(n < 300), 8'h01);
        end
        check("standby", 8'(stby), 8'h01);
    endtask : wr
    task automatic rd(input logic [7:0] dev, hi, lo, e0, e1, input logic two);
        HOST.start();
        send(dev);
        send(hi);
        send(lo);
        HOST.start();
        send(dev | 8'h01);
        HOST.xfer(8'hff, two, r, a);
        check("rdata", r, e0);
        check("sda out", 8'(sda_out), 8'h00);
        if (two) begin
            HOST.xfer(8'hff, 1'b0, r, a);
            check("rdata next", r, e1);
        end
        HOST.stop();
        HOST.tick(4);
        check("standby", 8'(stby), 8'h01);
    endtask : rd
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        wp = 1'b0;
        csu = 1'b0;
        csl = 1'b0;
        repeat (5) @(posedge clk);
        #2;
        rst = 1'b0;
        check("reset outs", 8'({stby, busy, sda_oe}), 8'h04);
        HOST.tick(6);
        foreach (ROWS[i]) begin
            {csu, csl} = ROWS[i][10:9];
            HOST.tick(8);
            HOST.start();
            HOST.xfer(ROWS[i][8:1], 1'b0, r, a);
            check("dev ack", 8'(a), 8'(ROWS[i][0]));
            HOST.stop();
            HOST.tick(4);
            check("standby", 8'(stby), 8'h01);
        end
        {csu, csl} = 2'b00;
        HOST.tick(8);
        wr(8'ha2, 8'hff, 8'hff, 8'h5a, 8'h00, 1'b0, 1'b1);
        wr(8'ha0, 8'h00, 8'hff, 8'hc3, 8'h3c, 1'b1, 1'b1);
        wp = 1'b1;
        HOST.tick(8);
        wr(8'ha2, 8'hff, 8'hff, 8'h00, 8'h00, 1'b0, 1'b0);
        // Reads stay open while the array is protected
        rd(8'ha2, 8'hff, 8'hff, 8'h5a, 8'h3c, 1'b1);
        wp = 1'b0;
        rd(8'ha0, 8'h00, 8'hff, 8'hc3, 8'h00, 1'b0);
        // Reset in mid-frame: back to standby, counter back to zero
        {csu, csl} = 2'b11;
        HOST.tick(8);
        HOST.start();
        send(8'hac);
        rst = 1'b1;
        HOST.tick(5);
        rst = 1'b0;
        check("reset mid", 8'({stby, busy, sda_oe}), 8'h04);
        HOST.stop();
        HOST.tick(4);
        HOST.start();
        send(8'had);
        HOST.xfer(8'hff, 1'b0, r, a);
        check("rdata after reset", r, 8'h3c);
        HOST.stop();
        HOST.tick(4);
        check("standby", 8'(stby), 8'h01);
        print_verdict();
    end
endmodule : tb_tws_top
`default_nettype wire
